// ### p0ssd_pkg.sv
// Package for the port 0 soft-strap default loader: strap carrier, register
// map, field positions and reset values.
// Assumes a 32-bit register port whose byte offsets are word aligned.
package p0ssd_pkg;

    // ==========================================================
    // Strap carrier
    // ==========================================================
    // Speed and duplex each hold one shared bit (select and polarity alike)
    typedef struct packed {
        logic heartbeat_test_off;
        logic speed;
        logic duplex;
        logic backpressure;
        logic fullduplex_flowctl;
    } p0ssd_strap_t;

    localparam p0ssd_strap_t STRAP_DEFAULT = '{
        heartbeat_test_off: 1'b0,
        speed: 1'b1,
        duplex: 1'b1,
        backpressure: 1'b1,
        fullduplex_flowctl: 1'b1
    };

    // Port 0 interface modes
    typedef enum logic [1:0] {
        MODE_MII_MAC,
        MODE_MII_PHY,
        MODE_RMII_PHY,
        MODE_RMII_MAC
    } p0ssd_mode_t;

    // ==========================================================
    // Register port
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } p0ssd_req_t;

    localparam logic [ADDR_W-1:0] OFS_SPECIAL_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PARTNER_ABILITY = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_MANUAL_FC = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STRAP_STATUS = 8'h0c;

    // Field positions
    localparam int BIT_HEARTBEAT_OFF = 11;
    localparam int BIT_AB_100FD = 8;
    localparam int BIT_AB_100HD = 7;
    localparam int BIT_AB_10FD = 6;
    localparam int BIT_AB_10HD = 5;
    localparam int BIT_FC_BP = 0;
    localparam int BIT_FC_TX = 1;
    localparam int BIT_FC_RX = 2;
    localparam int BIT_ST_STRAPS = 0;
    localparam int BIT_ST_IND_SPD = 5;
    localparam int BIT_ST_IND_FD = 6;
    localparam int BIT_ST_OPER_SPD = 7;

    // Ability bits under reset: 100FD only, matching the default straps
    localparam logic [3:0] ABILITY_RESET = 4'h8;

    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

endpackage

// ### p0ssd_strap_store.sv
// Stored soft-strap values of port 0 and the load pulse that applies them.
// Assumes strap pins are stable around reset release and that the EEPROM
// loader presents one valid pulse per override.
`timescale 1ns/1ps
`default_nettype none

module p0ssd_strap_store (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire p0ssd_pkg::p0ssd_strap_t i_strap_pins,
    input wire logic i_eep_valid,
    input wire p0ssd_pkg::p0ssd_strap_t i_eep_straps,
    output p0ssd_pkg::p0ssd_strap_t o_straps,
    output logic o_load
);

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    p0ssd_pkg::p0ssd_strap_t straps_ff;
    logic capture_pend_ff;
    logic load_ff;

    // ==========================================================
    // Strap capture and EEPROM override
    // ==========================================================
    // Pins are caught one cycle after release, never under reset itself
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            straps_ff <= p0ssd_pkg::STRAP_DEFAULT;
        end else if (i_eep_valid) begin
            straps_ff <= i_eep_straps; // see RULE10
        end else if (capture_pend_ff) begin
            straps_ff <= i_strap_pins;
        end
    end

    // Pending flag for the pin capture after reset
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            capture_pend_ff <= 1'b1;
        end else begin
            capture_pend_ff <= 1'b0;
        end
    end

    // One load pulse after every capture or reload
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            load_ff <= 1'b0;
        end else begin
            load_ff <= i_eep_valid | capture_pend_ff; // see RULE11
        end
    end

    assign o_straps = straps_ff;
    assign o_load = load_ff;

    a_eeprom_override: assert property ( // see RULE10
        i_eep_valid |=> (o_load && o_straps == $past(i_eep_straps))
    ) else $error("EEPROM strap override not applied");

endmodule

`default_nettype wire

// ### p0ssd_top.sv
// Port 0 soft-strap default loader: virtual PHY and manual flow control
// register bits, strap-driven fallback speed and indicator pin decoding.
// Assumes a register master that never issues read and write together.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: Heartbeat strap sets heartbeat-off bit default
// RULE2: Speed strap sets four partner ability defaults
// RULE3: Failed virtual negotiation falls back to strap speed
// RULE4: Speed and duplex each share one strap bit
// RULE5: RMII MAC speed pin read per polarity
// RULE6: Duplex strap sets four partner ability defaults
// RULE7: MII/RMII MAC duplex pin read per polarity
// RULE8: Backpressure strap sets backpressure enable default
// RULE9: Flow control strap sets tx/rx enables
// RULE10: EEPROM contents override pin straps first
// RULE11: Defaults reload on load; writes spare straps
module p0ssd_top (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire p0ssd_pkg::p0ssd_strap_t i_strap_pins,
    input wire logic i_eep_valid,
    input wire p0ssd_pkg::p0ssd_strap_t i_eep_straps,
    input wire p0ssd_pkg::p0ssd_req_t i_req,
    output logic [p0ssd_pkg::DATA_W-1:0] o_rdata,
    input wire p0ssd_pkg::p0ssd_mode_t i_p0_mode,
    input wire logic i_port0_speed_indicator_pin,
    input wire logic i_port0_duplex_indicator_pin,
    input wire logic i_vphy_an_fail,
    input wire logic i_vphy_an_speed_100,
    output logic o_oper_speed_100,
    output logic o_ind_speed_100,
    output logic o_ind_full_duplex,
    output logic o_heartbeat_off_bit,
    output logic o_p0_backpressure_enable,
    output logic o_p0_tx_pause_enable,
    output logic o_p0_rx_pause_enable
);

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);

    p0ssd_pkg::p0ssd_strap_t straps;
    logic load;

    logic heartbeat_off_bit_ff;
    logic [3:0] ability_ff;
    logic p0_backpressure_enable_ff;
    logic p0_tx_pause_enable_ff;
    logic p0_rx_pause_enable_ff;
    logic [p0ssd_pkg::DATA_W-1:0] rdata_ff;
    logic [p0ssd_pkg::DATA_W-1:0] nxt_rdata;
    logic oper_speed_100_ff;
    logic ind_speed_100_ff;
    logic ind_full_duplex_ff;
    logic [3:0] nxt_ability;
    logic wr_special;
    logic wr_ability;
    logic wr_fc;

    // ==========================================================
    // Strap storage
    // ==========================================================
    p0ssd_strap_store u_store (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_strap_pins(i_strap_pins),
        .i_eep_valid(i_eep_valid),
        .i_eep_straps(i_eep_straps),
        .o_straps(straps),
        .o_load(load)
    );

    // ==========================================================
    // Register write decode
    // ==========================================================
    assign wr_special = i_req.wr && (i_req.addr == p0ssd_pkg::OFS_SPECIAL_CTRL);
    assign wr_ability = i_req.wr && (i_req.addr == p0ssd_pkg::OFS_PARTNER_ABILITY);
    assign wr_fc = i_req.wr && (i_req.addr == p0ssd_pkg::OFS_MANUAL_FC);

    // Ability defaults: one bit per speed and duplex pairing
    // Index 3..0 is 100FD, 100HD, 10FD, 10HD
    always_comb begin
        nxt_ability[3] = straps.speed & straps.duplex; // see RULE2
        nxt_ability[2] = straps.speed & ~straps.duplex; // see RULE6
        nxt_ability[1] = ~straps.speed & straps.duplex;
        nxt_ability[0] = ~straps.speed & ~straps.duplex;
    end

    // ==========================================================
    // Strap-derived register bits
    // ==========================================================
    // A load beats a write in the same cycle so defaults are never lost
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            heartbeat_off_bit_ff <= p0ssd_pkg::STRAP_DEFAULT.heartbeat_test_off;
        end else if (load) begin
            heartbeat_off_bit_ff <= straps.heartbeat_test_off; // see RULE1
        end else if (wr_special) begin
            heartbeat_off_bit_ff <= i_req.wdata[p0ssd_pkg::BIT_HEARTBEAT_OFF];
        end
    end

    // Partner ability bits
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ability_ff <= p0ssd_pkg::ABILITY_RESET;
        end else if (load) begin
            ability_ff <= nxt_ability; // see RULE2
        end else if (wr_ability) begin
            ability_ff <= {i_req.wdata[p0ssd_pkg::BIT_AB_100FD],
                           i_req.wdata[p0ssd_pkg::BIT_AB_100HD],
                           i_req.wdata[p0ssd_pkg::BIT_AB_10FD],
                           i_req.wdata[p0ssd_pkg::BIT_AB_10HD]};
        end
    end

    // Manual flow control bits; writes touch only these, not the straps
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            p0_backpressure_enable_ff <= p0ssd_pkg::STRAP_DEFAULT.backpressure;
            p0_tx_pause_enable_ff <= p0ssd_pkg::STRAP_DEFAULT.fullduplex_flowctl;
            p0_rx_pause_enable_ff <= p0ssd_pkg::STRAP_DEFAULT.fullduplex_flowctl;
        end else if (load) begin
            p0_backpressure_enable_ff <= straps.backpressure; // see RULE8
            p0_tx_pause_enable_ff <= straps.fullduplex_flowctl; // see RULE9
            p0_rx_pause_enable_ff <= straps.fullduplex_flowctl;
        end else if (wr_fc) begin
            p0_backpressure_enable_ff <= i_req.wdata[p0ssd_pkg::BIT_FC_BP]; // see RULE11
            p0_tx_pause_enable_ff <= i_req.wdata[p0ssd_pkg::BIT_FC_TX];
            p0_rx_pause_enable_ff <= i_req.wdata[p0ssd_pkg::BIT_FC_RX];
        end
    end

    // ==========================================================
    // Speed fallback and indicator decoding
    // ==========================================================
    // One shared strap bit serves both select and polarity, see RULE4
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            oper_speed_100_ff <= p0ssd_pkg::STRAP_DEFAULT.speed;
        end else if (i_vphy_an_fail) begin
            oper_speed_100_ff <= straps.speed; // see RULE3
        end else begin
            oper_speed_100_ff <= i_vphy_an_speed_100;
        end
    end

    // Speed pin only meaningful in RMII MAC mode; otherwise held low
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ind_speed_100_ff <= 1'b0;
        end else if (i_p0_mode == p0ssd_pkg::MODE_RMII_MAC) begin
            ind_speed_100_ff <= (i_port0_speed_indicator_pin == straps.speed); // see RULE5
        end else begin
            ind_speed_100_ff <= 1'b0;
        end
    end

    // Duplex pin meaningful in both MAC modes
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ind_full_duplex_ff <= 1'b0;
        end else if ((i_p0_mode == p0ssd_pkg::MODE_MII_MAC) ||
                     (i_p0_mode == p0ssd_pkg::MODE_RMII_MAC)) begin
            ind_full_duplex_ff <= (i_port0_duplex_indicator_pin == straps.duplex); // see RULE7
        end else begin
            ind_full_duplex_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Register read path
    // ==========================================================
    // Unmapped offsets and idle cycles read as zero
    always_comb begin
        nxt_rdata = p0ssd_pkg::READ_ZERO;
        if (i_req.rd) begin
            case (i_req.addr)
                p0ssd_pkg::OFS_SPECIAL_CTRL: begin
                    nxt_rdata[p0ssd_pkg::BIT_HEARTBEAT_OFF] = heartbeat_off_bit_ff;
                end
                p0ssd_pkg::OFS_PARTNER_ABILITY: begin
                    nxt_rdata[p0ssd_pkg::BIT_AB_100FD] = ability_ff[3];
                    nxt_rdata[p0ssd_pkg::BIT_AB_100HD] = ability_ff[2];
                    nxt_rdata[p0ssd_pkg::BIT_AB_10FD] = ability_ff[1];
                    nxt_rdata[p0ssd_pkg::BIT_AB_10HD] = ability_ff[0];
                end
                p0ssd_pkg::OFS_MANUAL_FC: begin
                    nxt_rdata[p0ssd_pkg::BIT_FC_BP] = p0_backpressure_enable_ff;
                    nxt_rdata[p0ssd_pkg::BIT_FC_TX] = p0_tx_pause_enable_ff;
                    nxt_rdata[p0ssd_pkg::BIT_FC_RX] = p0_rx_pause_enable_ff;
                end
                p0ssd_pkg::OFS_STRAP_STATUS: begin
                    nxt_rdata[p0ssd_pkg::BIT_ST_STRAPS +: $bits(p0ssd_pkg::p0ssd_strap_t)] = straps;
                    nxt_rdata[p0ssd_pkg::BIT_ST_IND_SPD] = ind_speed_100_ff;
                    nxt_rdata[p0ssd_pkg::BIT_ST_IND_FD] = ind_full_duplex_ff;
                    nxt_rdata[p0ssd_pkg::BIT_ST_OPER_SPD] = oper_speed_100_ff;
                end
                default: begin
                    nxt_rdata = p0ssd_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            rdata_ff <= p0ssd_pkg::READ_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_oper_speed_100 = oper_speed_100_ff;
    assign o_ind_speed_100 = ind_speed_100_ff;
    assign o_ind_full_duplex = ind_full_duplex_ff;
    assign o_heartbeat_off_bit = heartbeat_off_bit_ff;
    assign o_p0_backpressure_enable = p0_backpressure_enable_ff;
    assign o_p0_tx_pause_enable = p0_tx_pause_enable_ff;
    assign o_p0_rx_pause_enable = p0_rx_pause_enable_ff;

    // ==========================================================
    // Checks
    // ==========================================================
    a_heartbeat_default: assert property ( // see RULE1
        load |=> o_heartbeat_off_bit == $past(straps.heartbeat_test_off)
    ) else $error("Heartbeat-off default not loaded");

    a_speed_ability: assert property ( // see RULE2
        load |=> (ability_ff[3] | ability_ff[2]) == $past(straps.speed)
    ) else $error("Speed strap not reflected in ability bits");

    a_speed_fallback: assert property ( // see RULE3
        (i_vphy_an_fail && !load && !i_eep_valid)[*2] |-> o_oper_speed_100 == straps.speed
    ) else $error("Fallback speed differs from strap");

    a_shared_bit: assert property ( // see RULE4
        (i_vphy_an_fail && i_p0_mode == p0ssd_pkg::MODE_RMII_MAC && i_port0_speed_indicator_pin)
        |=> o_ind_speed_100 == o_oper_speed_100
    ) else $error("Speed select and polarity disagree");

    a_speed_pin_decode: assert property ( // see RULE5
        (i_p0_mode == p0ssd_pkg::MODE_RMII_MAC)
        |=> o_ind_speed_100 == ($past(i_port0_speed_indicator_pin) == $past(straps.speed))
    ) else $error("Speed pin decoded with wrong polarity");

    a_duplex_ability: assert property ( // see RULE6
        load |=> (ability_ff[3] | ability_ff[1]) == $past(straps.duplex)
    ) else $error("Duplex strap not reflected in ability bits");

    a_duplex_pin_decode: assert property ( // see RULE7
        (i_p0_mode == p0ssd_pkg::MODE_MII_MAC || i_p0_mode == p0ssd_pkg::MODE_RMII_MAC)
        |=> o_ind_full_duplex == ($past(i_port0_duplex_indicator_pin) == $past(straps.duplex))
    ) else $error("Duplex pin decoded with wrong polarity");

    a_backpressure_default: assert property ( // see RULE8
        load |=> o_p0_backpressure_enable == $past(straps.backpressure)
    ) else $error("Backpressure default not loaded");

    a_pause_default: assert property ( // see RULE9
        load |=> (o_p0_tx_pause_enable == $past(straps.fullduplex_flowctl)) &&
                 (o_p0_rx_pause_enable == $past(straps.fullduplex_flowctl))
    ) else $error("Pause enable defaults not loaded");

    a_write_spares_straps: assert property ( // see RULE11
        (wr_fc && !load && !i_eep_valid && !$past(i_srst)) |=>
        (o_p0_backpressure_enable == $past(i_req.wdata[p0ssd_pkg::BIT_FC_BP])) && $stable(straps)
    ) else $error("Flow control write misbehaved");

endmodule

`default_nettype wire

// ### p0ssd_strap_src.sv
// Model of the far side of the strap loader: strap pin levels and the
// serial configuration EEPROM loader that delivers override straps.
// Assumes the bench commands each EEPROM delivery with a one-cycle go pulse.
`timescale 1ns/1ps
`default_nettype none

module p0ssd_strap_src (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire p0ssd_pkg::p0ssd_strap_t i_pin_level,
    input wire logic i_go,
    input wire logic [3:0] i_wait,
    input wire p0ssd_pkg::p0ssd_strap_t i_image,
    output p0ssd_pkg::p0ssd_strap_t o_strap_pins,
    output logic o_eep_valid,
    output p0ssd_pkg::p0ssd_strap_t o_eep_straps
);
    // ==========================================================
    // Strap pins and EEPROM delivery
    // ==========================================================
    logic busy_ff;
    logic [3:0] cnt_ff;
    p0ssd_pkg::p0ssd_strap_t image_ff;

    // Pin levels are held by their pull resistors
    assign o_strap_pins = i_pin_level;

    // Delivery after a chosen wait; zero wait answers promptly
    always_ff @(posedge i_clk_sys) begin
        o_eep_valid <= 1'b0;
        if (i_srst) begin
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end else if (i_go) begin
            busy_ff <= 1'b1;
            cnt_ff <= i_wait;
            image_ff <= i_image;
        end else if (busy_ff && cnt_ff == 4'h0) begin
            busy_ff <= 1'b0;
            o_eep_valid <= 1'b1;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    // Outside the pulse the data lines carry junk, so stale data cannot pass
    assign o_eep_straps = o_eep_valid ? image_ff : p0ssd_pkg::p0ssd_strap_t'(~image_ff);
endmodule
`default_nettype wire

// ### p0ssd_tb_top.sv
// Self-checking bench for the port 0 soft-strap default loader.
// Assumes the strap source model and the one-cycle register read timing.
`timescale 1ns/1ps
`default_nettype none

module p0ssd_tb_top;
    // ==========================================================
    // Stimulus, model and design
    // ==========================================================
    logic i_clk_sys = 1'b0;
    logic i_srst = 1'b1;
    p0ssd_pkg::p0ssd_strap_t pin_lvl = p0ssd_pkg::STRAP_DEFAULT;
    p0ssd_pkg::p0ssd_strap_t img = '0;
    p0ssd_pkg::p0ssd_strap_t pins_w, eep_w, pins_s, eep_s;
    logic go = 1'b0;
    logic [3:0] wt = 4'h0;
    logic eep_vld;
    p0ssd_pkg::p0ssd_req_t req = '0;
    logic [31:0] rdata, ex, abw;
    p0ssd_pkg::p0ssd_mode_t mode = p0ssd_pkg::MODE_MII_MAC;
    logic spd_pin = 1'b0, dpx_pin = 1'b0, an_fail = 1'b0, an100 = 1'b0;
    logic oper, ind_spd, ind_fd, hb, bp, txp, rxp;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    logic [31:0] exp_q[$];
    logic rd_pend = 1'b0;

    always #5 i_clk_sys = ~i_clk_sys;

    p0ssd_strap_src SRC (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_pin_level(pin_lvl),
        .i_go(go), .i_wait(wt), .i_image(img), .o_strap_pins(pins_s),
        .o_eep_valid(eep_vld), .o_eep_straps(eep_s));

    p0ssd_top DUT (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_strap_pins(pins_s),
        .i_eep_valid(eep_vld), .i_eep_straps(eep_s), .i_req(req), .o_rdata(rdata),
        .i_p0_mode(mode), .i_port0_speed_indicator_pin(spd_pin),
        .i_port0_duplex_indicator_pin(dpx_pin), .i_vphy_an_fail(an_fail),
        .i_vphy_an_speed_100(an100), .o_oper_speed_100(oper), .o_ind_speed_100(ind_spd),
        .o_ind_full_duplex(ind_fd), .o_heartbeat_off_bit(hb),
        .o_p0_backpressure_enable(bp), .o_p0_tx_pause_enable(txp),
        .o_p0_rx_pause_enable(rxp));

    // ==========================================================
    // Checking helpers
    // ==========================================================
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Ability bits expected from the shared speed and duplex strap bits
    function automatic logic [31:0] abil(p0ssd_pkg::p0ssd_strap_t s);
        return {23'h0, s.speed & s.duplex, s.speed & ~s.duplex, ~s.speed & s.duplex,
            ~s.speed & ~s.duplex, 5'h0};
    endfunction

    // Status word expected from straps and the present pin and mode inputs
    function automatic logic [31:0] stat(p0ssd_pkg::p0ssd_strap_t s);
        logic os, is, id;
        os = an_fail ? s.speed : an100;
        is = (mode == p0ssd_pkg::MODE_RMII_MAC) && (spd_pin == s.speed);
        id = (mode == p0ssd_pkg::MODE_MII_MAC || mode == p0ssd_pkg::MODE_RMII_MAC)
            && (dpx_pin == s.duplex);
        return {24'h0, os, id, is, s};
    endfunction

    // One register cycle; for a read, d is the expected data, noted in the queue
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        if (!w) exp_q.push_back(d);
        @(posedge i_clk_sys);
        req <= '0;
    endtask

    // Read data stands only in the cycle after the strobe, so look there
    always @(posedge i_clk_sys) begin
        if (rd_pend) check("read data", rdata, exp_q.pop_front());
        rd_pend <= req.rd;
    end

    task automatic do_reset(input p0ssd_pkg::p0ssd_strap_t s);
        @(posedge i_clk_sys);
        i_srst <= 1'b1;
        pin_lvl <= s;
        repeat (5) @(posedge i_clk_sys);
        i_srst <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic eep_load(input p0ssd_pkg::p0ssd_strap_t s, input logic [3:0] w);
        @(posedge i_clk_sys);
        go <= 1'b1;
        img <= s;
        wt <= w;
        @(posedge i_clk_sys);
        go <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(posedge i_clk_sys);
            if (eep_vld === 1'b1) break;
        end
        repeat (3) @(posedge i_clk_sys);
        #1;
    endtask

    // Register bits and read-back must all follow the given straps
    task automatic chk_defaults(input p0ssd_pkg::p0ssd_strap_t s);
        check("heartbeat bit", 32'(hb), 32'(s.heartbeat_test_off));
        check("backpressure", 32'(bp), 32'(s.backpressure));
        check("pause enables", 32'({txp, rxp}), 32'({2{s.fullduplex_flowctl}}));
        bus(1'b0, p0ssd_pkg::OFS_SPECIAL_CTRL, 32'(s.heartbeat_test_off) << 11);
        bus(1'b0, p0ssd_pkg::OFS_PARTNER_ABILITY, abil(s));
        bus(1'b0, p0ssd_pkg::OFS_MANUAL_FC,
            32'({{2{s.fullduplex_flowctl}}, s.backpressure}));
        bus(1'b0, p0ssd_pkg::OFS_STRAP_STATUS, stat(s));
    endtask

    // A hang is cut short well past the expected run length
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            $display("[FAIL] cycle limit expected done seen hang");
            close_out();
        end
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        void'($urandom(32'ha524));
        // Every speed and duplex strap pair, then the plain defaults
        for (int i = 0; i < 5; i++) begin
            pins_w = p0ssd_pkg::p0ssd_strap_t'(5'($urandom));
            pins_w.speed = i[0];
            pins_w.duplex = i[1];
            if (i == 4) pins_w = p0ssd_pkg::STRAP_DEFAULT;
            do_reset(pins_w);
            chk_defaults(pins_w);
            for (int k = 0; k < 16; k++) begin
                @(posedge i_clk_sys);
                mode <= p0ssd_pkg::p0ssd_mode_t'(k[1:0]);
                spd_pin <= k[2];
                dpx_pin <= k[3];
                an_fail <= 1'($urandom);
                an100 <= 1'($urandom);
                repeat (2) @(posedge i_clk_sys);
                #1;
                ex = stat(pins_w);
                check("indicators", 32'({oper, ind_fd, ind_spd}), 32'(ex[7:5]));
                bus(1'b0, p0ssd_pkg::OFS_STRAP_STATUS, stat(pins_w));
            end
            $display("test strap set %0d done", i);
        end
        // Writes change the bits, spare the straps; unmapped place stays empty
        abw = {23'h0, 4'($urandom), 5'h0};
        bus(1'b1, p0ssd_pkg::OFS_MANUAL_FC, 32'h0);
        bus(1'b1, p0ssd_pkg::OFS_SPECIAL_CTRL, 32'h0000_0800);
        bus(1'b1, p0ssd_pkg::OFS_PARTNER_ABILITY, abw);
        bus(1'b1, 8'h10, 32'hffff_ffff);
        #1;
        check("flow ctrl after write", 32'({rxp, txp, bp}), 32'h0);
        check("heartbeat after write", 32'(hb), 32'h1);
        bus(1'b0, p0ssd_pkg::OFS_PARTNER_ABILITY, abw);
        bus(1'b0, 8'h10, 32'h0);
        bus(1'b0, p0ssd_pkg::OFS_STRAP_STATUS, stat(pins_w));
        $display("test software writes done");
        // EEPROM overrides, prompt and slow, reload the defaults
        for (int j = 0; j < 2; j++) begin
            eep_w = p0ssd_pkg::p0ssd_strap_t'(5'($urandom));
            eep_load(eep_w, j == 0 ? 4'h0 : 4'h9);
            chk_defaults(eep_w);
            bus(1'b1, p0ssd_pkg::OFS_MANUAL_FC, 32'h0);
        end
        $display("test eeprom override done");
        close_out();
    end
endmodule
`default_nettype wire
